/* pkg/pmr_map.svh */
// register offsets, field positions, reset values and fixed codes
// Summary of operation
// - control bit 9 restarts negotiation, self-clears
// - control bit 8 selects duplex, resets zero
// - single-mode PHY forces duplex bit value
// - loopback ignores the duplex bit
// - control bit 7 forces collision on transmit
// - status bits 14:11 read one
// - status bit 6 reads zero
// - status bit 5 shows negotiation complete
// - status bit 4 reads zero
// - status bits 3 and 0 read one
// - status bit 2 link, latching low
// - status bit 1 jabber, latching high
// - registers 2 and 3 give identifier
// - advertise bits 15 and 14 read zero
// - advertise bit 13 writable remote fault
// - advertise bits 12:5 writable, reset 00101111
// - advertise selector fixed at 00001
// - register 5 mirrors partner advertisement
// - partner bit 14 is acknowledge
// - status bits 15, 10:7 read zero
// - access only through management data port
`ifndef PMR_MAP_SVH
`define PMR_MAP_SVH
`define PMR_REG_CONTROL   5'h00
`define PMR_REG_STATUS    5'h01
`define PMR_REG_ID_HIGH   5'h02
`define PMR_REG_ID_LOW    5'h03
`define PMR_REG_ADVERTISE 5'h04
`define PMR_REG_PARTNER   5'h05
`define PMR_CTL_RESTART   9
`define PMR_CTL_DUPLEX    8
`define PMR_CTL_COLTEST   7
`define PMR_ADV_FAULT     13
`define PMR_ADV_TECH_RST  8'h2f
`define PMR_ADV_SELECTOR  5'h01
`define PMR_STAT_ABILITY  16'h7809
`endif

/* pkg/pmr_pkg.sv */
// types shared by the management register bank
package pmr_pkg;
	typedef struct packed {
		logic       restart;
		logic       duplex;
		logic       colTest;
		logic       advFault;
		logic [7:0] advTech;
		logic       linkLatch;
		logic       jabberLatch;
		logic       restartPulse;
		logic [15:0] rdData;
		logic       link1;
		logic       link2;
		logic       jab1;
		logic       jab2;
	} pmr_state_t;
endpackage

/* verilog/pmr_regs.sv */
// management register bank: control, status, identifier, ability
`timescale 1ns/1ps
`include "pmr_map.svh"
module pmr_regs
	import pmr_pkg::*;
#(
	parameter logic [15:0] ID_HIGH     = 16'h1234, // arbitrary value
	parameter logic [15:0] ID_LOW      = 16'h5678, // arbitrary value
	parameter logic        HALF_ONLY   = 1'b0,
	parameter logic        FULL_ONLY   = 1'b0
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        mgmtWrite,
	input  wire logic        mgmtRead,
	input  wire logic [4:0]  mgmtAddr,
	input  wire logic [15:0] mgmtWrData,
	output logic      [15:0] mgmtRdData,
	input  wire logic        linkUp,
	input  wire logic        jabber,
	input  wire logic        anegDone,
	input  wire logic [15:0] partnerWord,
	input  wire logic        loopback,
	input  wire logic        txEnable,
	output logic             collision,
	output logic             anegRestart,
	output logic             duplexFull
);
	pmr_state_t s_q;
	pmr_state_t s_d;
	logic [15:0] statusWord;

	// status word from fixed abilities and latched bits
	always_comb begin
		statusWord = `PMR_STAT_ABILITY;
		statusWord[5] = anegDone;
		statusWord[2] = s_q.linkLatch;
		statusWord[1] = s_q.jabberLatch;
	end

	// next state: writes, latches, reads
	always_comb begin
		s_d = s_q;
		s_d.link1 = linkUp;
		s_d.link2 = s_q.link1;
		s_d.jab1 = jabber;
		s_d.jab2 = s_q.jab1;
		s_d.restartPulse = 1'b0;
		s_d.restart = 1'b0;
		// register access through management port only
		if (mgmtWrite) begin
			case (mgmtAddr)
				`PMR_REG_CONTROL: begin
					s_d.restartPulse = mgmtWrData[`PMR_CTL_RESTART];
					s_d.duplex = mgmtWrData[`PMR_CTL_DUPLEX];
					s_d.colTest = mgmtWrData[`PMR_CTL_COLTEST];
				end
				`PMR_REG_ADVERTISE: begin
					s_d.advFault = mgmtWrData[`PMR_ADV_FAULT];
					s_d.advTech = mgmtWrData[12:5];
				end
				default: begin
				end
			endcase
		end
		if (HALF_ONLY)
			s_d.duplex = 1'b0;
		if (FULL_ONLY)
			s_d.duplex = 1'b1;
		// read capture; latches rearm on status read
		if (mgmtRead) begin
			case (mgmtAddr)
				`PMR_REG_CONTROL:
					s_d.rdData = {6'h00, s_q.restart, s_q.duplex,
						s_q.colTest, 7'h00};
				`PMR_REG_STATUS: begin
					s_d.rdData = statusWord;
					s_d.linkLatch = s_q.link2;
					s_d.jabberLatch = s_q.jab2;
				end
				`PMR_REG_ID_HIGH: s_d.rdData = ID_HIGH;
				`PMR_REG_ID_LOW:  s_d.rdData = ID_LOW;
				`PMR_REG_ADVERTISE:
					s_d.rdData = {2'b00, s_q.advFault, s_q.advTech,
						`PMR_ADV_SELECTOR};
				`PMR_REG_PARTNER: s_d.rdData = partnerWord;
				default: s_d.rdData = 16'h0000;
			endcase
		end
		// latch-low link and latch-high jabber; event wins over read
		if (!s_q.link2)
			s_d.linkLatch = 1'b0;
		if (s_q.jab2)
			s_d.jabberLatch = 1'b1;
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.advTech <= `PMR_ADV_TECH_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs
	assign mgmtRdData  = s_q.rdData;
	assign anegRestart = s_q.restartPulse;
	assign duplexFull  = s_q.duplex & ~loopback;
	assign collision   = s_q.colTest & txEnable;
endmodule

/* tb/pmr_regs_monitor.sv */
// port assertions for the management register bank
`timescale 1ns/1ps
module pmr_regs_monitor (
	input wire logic        clk, rst, mgmtWrite, mgmtRead, anegDone,
	input wire logic        loopback, txEnable, collision, anegRestart,
	input wire logic        duplexFull,
	input wire logic [4:0]  mgmtAddr,
	input wire logic [15:0] mgmtWrData, mgmtRdData
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// decoded accesses
	wire wrCtl = mgmtWrite && mgmtAddr == 5'h00;
	wire rdSt  = mgmtRead && mgmtAddr == 5'h01;
	wire rdAdv = mgmtRead && mgmtAddr == 5'h04;
	AST_RESTART: assert property (wrCtl && mgmtWrData[9] |=>
		anegRestart ##1 !anegRestart) else $error("restart pulse");
	AST_COLTEST: assert property (wrCtl ##2 txEnable |->
		collision == $past(mgmtWrData[7], 2)) else $error("collision");
	AST_DUPLEX: assert property (wrCtl && !loopback ##1 !loopback |->
		duplexFull == $past(mgmtWrData[8])) else $error("duplex");
	AST_LOOP: assert property (loopback |-> !duplexFull)
		else $error("loopback duplex");
	AST_ABILITY: assert property (rdSt |=> mgmtRdData[15:6] == 10'h1e0)
		else $error("ability bits");
	AST_FIXED: assert property (rdSt |=> mgmtRdData[4:3] == 2'b01
		&& mgmtRdData[0]) else $error("fixed status bits");
	AST_ANEG: assert property (rdSt |=> mgmtRdData[5] == $past(anegDone))
		else $error("negotiation done");
	AST_SELECT: assert property (rdAdv |=> mgmtRdData[4:0] == 5'h01
		&& mgmtRdData[15:14] == 2'b00) else $error("selector");
	// main scenarios
	cover property (anegRestart);
	cover property (txEnable && collision);
	cover property (rdSt && anegDone);
endmodule
bind pmr_regs pmr_regs_monitor u_pmr_regs_monitor (.*);

/* tb/pmr_host.sv */
// management host model issuing register accesses
`timescale 1ns/1ps
module pmr_host (
	input  wire logic        clk,
	input  wire logic [15:0] mgmtRdData,
	output logic             mgmtWrite,
	output logic             mgmtRead,
	output logic      [4:0]  mgmtAddr,
	output logic      [15:0] mgmtWrData
);
	initial {mgmtWrite, mgmtRead, mgmtAddr, mgmtWrData} = '0;
	// raise, hold to the taking edge, release with scrambled lines
	task automatic acc(input logic w, input logic [4:0] a,
		input logic [15:0] d, output logic [15:0] q);
		@(posedge clk);
		{mgmtWrite, mgmtRead, mgmtAddr} <= {w, !w, a};
		mgmtWrData <= a == 5'h00 ? d & 16'hff80 : d;
		@(posedge clk);
		{mgmtWrite, mgmtRead, mgmtAddr, mgmtWrData} <= {2'b00, ~a, ~d};
		#1 q = mgmtRdData;
	endtask
endmodule

/* tb/pmr_regs_tb_top.sv */
// self-checking bench for the management register bank
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	errors++; $display("ERROR %0t got %h want %h", $time, g, e); end end
module pmr_regs_tb_top;
	logic clk = 0, rst = 1, linkUp = 0, jabber = 0, anegDone = 0;
	logic loopback = 0, txEnable = 0, mgmtWrite, mgmtRead;
	logic collision, anegRestart, duplexFull;
	logic [4:0] mgmtAddr;
	logic [15:0] mgmtWrData, mgmtRdData, q, partnerWord = 16'hc5a1;
	int errors = 0, samples_checked = 0, cyc = 0;
	always #2 clk = ~clk;
	pmr_regs u_pmr_regs (.*);
	pmr_host u_pmr_host (.*);
	task summarize;
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge clk) if (++cyc == 2000) begin errors++; summarize; end
	task rd(input logic [4:0] a); u_pmr_host.acc(0, a, '0, q); endtask
	task wr(input logic [4:0] a, input logic [15:0] d);
		u_pmr_host.acc(1, a, d, q);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		{rst, linkUp} <= 2'b01;
		repeat (4) @(posedge clk); // link through the two-flop sync first
		rd(1); `CHK(q, 16'h7809)
		rd(1); `CHK(q, 16'h780d)
		rd(2); `CHK(q, 16'h1234)
		rd(3); `CHK(q, 16'h5678)
		rd(4); `CHK(q, 16'h05e1)
		rd(5); `CHK(q, 16'hc5a1)
		rd(31); `CHK(q, 16'h0000)
		wr(4, 16'hffff); rd(4); `CHK(q, 16'h3fe1)
		wr(4, 16'h0000); rd(4); `CHK(q, 16'h0001)
		$display("test reads done");
		wr(0, 16'h03ff); rd(0); `CHK(q[9:0], 10'h180)
		@(posedge clk) txEnable <= 1;
		@(negedge clk) `CHK({collision, duplexFull}, 2'b11)
		@(posedge clk) loopback <= 1;
		@(negedge clk) `CHK(duplexFull, 1'b0)
		wr(0, 16'h0000);
		@(negedge clk) `CHK(collision, 1'b0)
		$display("test control done");
		@(posedge clk) {anegDone, jabber} <= 2'b11;
		repeat (4) @(posedge clk);
		{jabber, linkUp} <= 2'b00;
		repeat (4) @(posedge clk);
		linkUp <= 1;
		repeat (4) @(posedge clk);
		rd(1); `CHK(q, 16'h782b)
		rd(1); `CHK(q, 16'h782d)
		$display("test latches done");
		summarize;
	end
endmodule
